/* File: logic/ars_sequencer.sv */
`timescale 1ns/1ps

// Notes on behaviour
// [R01] At most eight reclose attempts per fault
// [R02] Cycles five onward reuse fourth parameter set
// [R03] Three switch sources, state kept non-volatile
// [R04] Switch on only from the switching-off source
// [R05] Active only when all three sources on
// [R06] Setting/interface switching refused during fault
// [R07] Readiness outputs for first and later cycles
// [R08] First enabled trip latched once per fault
// [R09] Optional breaker-ready check blocks start
// [R10] Per-source bit allows trip to start
// [R11] Non-short-circuit trips never start reclosure
// [R12] Mode selects action times; else start on trip
// [R13] Per-set action timers start from ORed pickups
// [R14] Expired timer without trip: cycle not performable
// [R15] Start permission per cycle gates first start
// [R16] Expired cycle skipped to next permitted one
// [R17] Common ms tick; reset returns to idle
module ars_sequencer
  import ars_pkg::*;
#(
  parameter int NUM_SRC     = 4,
  parameter int NUM_CYCLES  = ARS_MAX_CYCLES,
  parameter int TICK_CYCLES = ARS_TICK_CYCLES
) (
  input  wire logic                   core_clk_in,
  input  wire logic                   rst_in,
  input  wire ars_switch_req_type     sw_req_in [ARS_NUM_SWITCH],
  input  wire logic                   nv_load_in,
  input  wire logic [2:0]             nv_state_in,
  input  wire ars_mode_type           reclose_timing_mode_in,
  input  wire ars_cycle_set_type      cycle_set_in [ARS_NUM_SETS],
  input  wire logic [NUM_SRC-1:0]     src_reclose_en_in,
  input  wire logic [NUM_SRC-1:0]     src_pickup_in,
  input  wire logic [NUM_SRC-1:0]     src_trip_in,
  input  wire logic                   nonsc_trip_in,
  input  wire logic                   cb_ready_in,
  input  wire logic                   cb_check_en_in,
  output logic [2:0]                  switch_off_state_out,
  output logic                        reclose_enable_setting_function_out,
  output logic [NUM_CYCLES-1:0]       cycle_ready_out,
  output logic                        started_out,
  output logic [2:0]                  cycle_out,
  output logic                        three_pole_out,
  output logic                        reclose_cmd_out,
  output logic                        lockout_out,
  output logic [ARS_NUM_SETS-1:0]     not_performable_out,
  output logic                        fault_busy_out
);

  if (NUM_CYCLES < 1 || NUM_CYCLES > ARS_MAX_CYCLES || NUM_SRC < 1
      || TICK_CYCLES < 2) begin : g_bad_param
    $error("ars_sequencer parameters out of range");
  end

  localparam int TW = $clog2(TICK_CYCLES);

  function automatic logic [1:0] set_of(input logic [2:0] cyc);
    set_of = (cyc > 3'h3) ? 2'h3 : cyc[1:0]; // [R02]
  endfunction : set_of

  // Time base
  logic [TW-1:0] tick_cnt_reg;
  logic [TW-1:0] tick_cnt_next;
  logic          tick;

  always_comb begin
    tick          = (tick_cnt_reg == TW'(TICK_CYCLES - 1)); // [R17]
    tick_cnt_next = tick ? '0 : tick_cnt_reg + TW'(1);
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
    end
  end

  // Switching state, bit set means switched off by that source
  logic [2:0]    sw_off_reg;
  logic [2:0]    sw_off_next;
  logic          active;
  ars_state_type state_reg;
  ars_state_type state_next;
  logic          busy;

  always_comb begin
    busy        = (state_reg != ARS_IDLE) || nonsc_trip_in;
    sw_off_next = sw_off_reg;
    if (nv_load_in) begin
      sw_off_next = nv_state_in; // [R03]
    end else begin
      for (int i = 0; i < ARS_NUM_SWITCH; i++) begin
        if (!(busy && i != ARS_SW_BINARY)) begin // [R06]
          if (sw_req_in[i].off_req) begin
            sw_off_next[i] = 1'b1;
          end else if (sw_req_in[i].on_req) begin
            sw_off_next[i] = 1'b0; // [R04]
          end
        end
      end
    end
    active = (sw_off_reg == 3'h0); // [R05]
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sw_off_reg <= ARS_SWITCH_RESET;
    end else begin
      sw_off_reg <= sw_off_next;
    end
  end

  // Start-capable sources only; non-short-circuit trips kept apart
  logic pickup_any;
  logic trip_any;
  logic pickup_d_reg;
  logic pickup_rise;

  always_comb begin
    pickup_any  = |(src_pickup_in & src_reclose_en_in); // [R13]
    trip_any    = |(src_trip_in & src_reclose_en_in); // [R10] [R11]
    pickup_rise = pickup_any && !pickup_d_reg;
  end

  // Action timers, one per parameter set
  logic [ARS_TIME_W-1:0]   act_cnt_reg [ARS_NUM_SETS];
  logic [ARS_TIME_W-1:0]   act_cnt_next [ARS_NUM_SETS];
  logic [ARS_NUM_SETS-1:0] expired;
  logic                    timers_clr;
  logic [ARS_NUM_SETS-1:0] np_reg;
  logic [ARS_NUM_SETS-1:0] np_next;
  logic                    waiting_trip;

  genvar g;
  generate
    for (g = 0; g < ARS_NUM_SETS; g++) begin : g_act
      always_comb begin
        expired[g] = (reclose_timing_mode_in == ARS_MODE_ACTION)
                     && (act_cnt_reg[g] >= cycle_set_in[g].action_ms); // [R13]
        if (timers_clr) begin
          act_cnt_next[g] = '0;
        end else if (tick && !expired[g] && act_cnt_reg[g] != '1) begin
          act_cnt_next[g] = act_cnt_reg[g] + ARS_TIME_W'(1);
        end else begin
          act_cnt_next[g] = act_cnt_reg[g];
        end
        if (state_reg == ARS_IDLE) begin
          np_next[g] = 1'b0;
        end else begin
          np_next[g] = np_reg[g] || (expired[g] && waiting_trip && !trip_any); // [R14]
        end
      end
      always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
          act_cnt_reg[g] <= '0;
          np_reg[g]      <= 1'b0;
        end else begin
          act_cnt_reg[g] <= act_cnt_next[g];
          np_reg[g]      <= np_next[g];
        end
      end
    end
  endgenerate

  // Cycle search
  logic       first_ok;
  logic [2:0] first_cyc;
  logic       next_ok;
  logic [2:0] next_cyc;
  logic [2:0] cur_reg;
  logic [2:0] cur_next;

  always_comb begin
    first_ok  = 1'b0;
    first_cyc = 3'h0;
    next_ok   = 1'b0;
    next_cyc  = 3'h0;
    for (int c = NUM_CYCLES - 1; c >= 0; c--) begin
      if (cycle_set_in[set_of(3'(c))].start_allowed // [R15]
          && !expired[set_of(3'(c))]) begin // [R16]
        first_ok  = 1'b1;
        first_cyc = 3'(c);
      end
      if (c > int'(cur_reg) && !expired[set_of(3'(c))]) begin // [R01] [R16]
        next_ok  = 1'b1;
        next_cyc = 3'(c);
      end
    end
  end

  // Sequencer
  logic [ARS_TIME_W-1:0] seq_cnt_reg;
  logic [ARS_TIME_W-1:0] seq_cnt_next;
  logic                  started_reg;
  logic                  started_next;
  logic                  reclose_reg;
  logic                  reclose_next;
  logic                  cb_ok;

  always_comb begin
    state_next   = state_reg;
    cur_next     = cur_reg;
    seq_cnt_next = seq_cnt_reg;
    started_next = started_reg;
    reclose_next = 1'b0;
    timers_clr   = 1'b0;
    waiting_trip = 1'b0;
    cb_ok        = cb_ready_in || !cb_check_en_in; // [R09]
    if (tick && seq_cnt_reg != '1) begin
      seq_cnt_next = seq_cnt_reg + ARS_TIME_W'(1);
    end
    unique case (state_reg)
      ARS_IDLE: begin
        started_next = 1'b0;
        timers_clr   = 1'b1;
        cur_next     = 3'h0;
        if (active && trip_any) begin
          if (!cb_ok || !first_ok) begin // [R12]
            state_next = ARS_LOCKOUT;
          end else begin
            started_next = 1'b1; // [R08]
            cur_next     = first_cyc;
            state_next   = ARS_TRIPPED;
          end
        end else if (active && pickup_any
                     && reclose_timing_mode_in == ARS_MODE_ACTION) begin
          state_next = ARS_PICKUP; // [R13]
        end
      end
      ARS_PICKUP: begin
        waiting_trip = 1'b1;
        if (trip_any) begin
          if (!cb_ok || !first_ok) begin // [R09] [R15]
            state_next = ARS_LOCKOUT;
          end else begin
            started_next = 1'b1; // [R08]
            cur_next     = first_cyc; // [R16]
            state_next   = ARS_TRIPPED;
          end
        end else if (!pickup_any) begin
          state_next = ARS_IDLE;
        end
      end
      ARS_TRIPPED: begin
        seq_cnt_next = '0;
        if (!trip_any) begin
          state_next = ARS_DEAD;
        end
      end
      ARS_DEAD: begin
        if (trip_any) begin
          state_next = ARS_TRIPPED;
        end else if (seq_cnt_reg >= cycle_set_in[set_of(cur_reg)].dead_ms) begin // [R02]
          reclose_next = 1'b1;
          seq_cnt_next = '0;
          state_next   = ARS_RECLAIM;
        end
      end
      ARS_RECLAIM: begin
        waiting_trip = 1'b1;
        timers_clr   = pickup_rise; // [R13]
        if (trip_any) begin
          if (started_reg && next_ok) begin // [R01] [R08]
            cur_next   = next_cyc;
            state_next = ARS_TRIPPED;
          end else begin
            state_next = ARS_LOCKOUT;
          end
        end else if (seq_cnt_reg >= ARS_RECLAIM_MS) begin
          started_next = 1'b0; // [R08]
          state_next   = ARS_IDLE;
        end
      end
      ARS_LOCKOUT: begin
        started_next = 1'b0;
        if (!trip_any && !pickup_any) begin
          state_next = ARS_IDLE;
        end
      end
      default: begin
        state_next = ARS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg    <= ARS_IDLE; // [R17]
      cur_reg      <= 3'h0;
      seq_cnt_reg  <= '0;
      started_reg  <= 1'b0;
      reclose_reg  <= 1'b0;
      pickup_d_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      cur_reg      <= cur_next;
      seq_cnt_reg  <= seq_cnt_next;
      started_reg  <= started_next;
      reclose_reg  <= reclose_next;
      pickup_d_reg <= pickup_any;
    end
  end

  // Readiness: first cycle from idle, later cycles during reclaim
  generate
    for (g = 0; g < NUM_CYCLES; g++) begin : g_rdy
      if (g == 0) begin : g_first
        assign cycle_ready_out[g] = active && (state_reg == ARS_IDLE); // [R07]
      end else begin : g_later
        assign cycle_ready_out[g] = active && (state_reg == ARS_RECLAIM)
                                    && (cur_reg == 3'(g - 1)); // [R07]
      end
    end
  endgenerate

  assign switch_off_state_out      = sw_off_reg;
  assign reclose_enable_setting_function_out = active;
  assign started_out               = started_reg;
  assign cycle_out                 = cur_reg;
  assign three_pole_out            = cycle_set_in[set_of(cur_reg)].three_pole;
  assign reclose_cmd_out           = reclose_reg;
  assign lockout_out               = (state_reg == ARS_LOCKOUT);
  assign not_performable_out       = np_reg;
  assign fault_busy_out            = busy;

endmodule : ars_sequencer

/* File: include/ars_pkg.sv */
package ars_pkg;

  localparam int          ARS_MAX_CYCLES   = 8;
  localparam int          ARS_NUM_SETS     = 4;
  localparam int          ARS_NUM_SWITCH   = 3;
  localparam int          ARS_SW_SETTING   = 0;
  localparam int          ARS_SW_SYSIF     = 1;
  localparam int          ARS_SW_BINARY    = 2;
  localparam int          ARS_CLK_PERIOD_NS = 50;
  localparam int          ARS_TICK_NS      = 1000000;
  localparam int          ARS_TICK_CYCLES  = (ARS_TICK_NS + ARS_CLK_PERIOD_NS - 1)
                                             / ARS_CLK_PERIOD_NS;
  localparam int          ARS_TIME_W       = 16;
  localparam logic [15:0] ARS_RECLAIM_MS   = 16'h0BB8;
  localparam logic [2:0]  ARS_SWITCH_RESET = 3'h0;

  typedef enum logic {
    ARS_MODE_NO_ACTION = 1'b0,
    ARS_MODE_ACTION    = 1'b1
  } ars_mode_type;

  typedef enum logic [2:0] {
    ARS_IDLE    = 3'b000,
    ARS_PICKUP  = 3'b001,
    ARS_TRIPPED = 3'b010,
    ARS_DEAD    = 3'b011,
    ARS_RECLAIM = 3'b100,
    ARS_LOCKOUT = 3'b101
  } ars_state_type;

  typedef struct packed {
    logic [ARS_TIME_W-1:0] action_ms;
    logic [ARS_TIME_W-1:0] dead_ms;
    logic                  start_allowed;
    logic                  three_pole;
  } ars_cycle_set_type;

  typedef struct packed {
    logic on_req;
    logic off_req;
  } ars_switch_req_type;

endpackage : ars_pkg

/* File: verif/ars_sequencer_props.sv */
`timescale 1ns/1ps
module ars_sequencer_props
  import ars_pkg::*;
#(
  parameter int NUM_SRC    = 4,
  parameter int NUM_CYCLES = ARS_MAX_CYCLES
) (
  input  wire logic                    core_clk_in,
  input  wire logic                    rst_in,
  input  wire ars_switch_req_type      sw_req_in [ARS_NUM_SWITCH],
  input  wire logic                    nv_load_in,
  input  wire logic [NUM_SRC-1:0]      src_reclose_en_in,
  input  wire logic [NUM_SRC-1:0]      src_trip_in,
  input  wire logic                    cb_ready_in,
  input  wire logic                    cb_check_en_in,
  input  wire logic [2:0]              switch_off_state_out,
  input  wire logic                    reclose_enable_setting_function_out,
  input  wire logic [NUM_CYCLES-1:0]   cycle_ready_out,
  input  wire logic                    started_out,
  input  wire logic [2:0]              cycle_out,
  input  wire logic                    reclose_cmd_out,
  input  wire logic                    lockout_out,
  input  wire logic [ARS_NUM_SETS-1:0] not_performable_out,
  input  wire logic                    fault_busy_out
);
  logic [3:0] shots_reg;
  logic [3:0] shots_next;
  default clocking cb_main @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // Reclose commands within one fault
  always_comb begin
    shots_next = shots_reg;
    if (!fault_busy_out) shots_next = 4'h0;
    else if (reclose_cmd_out) shots_next = shots_reg + 4'h1;
  end
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) shots_reg <= 4'h0;
    else shots_reg <= shots_next;
  end
  active_all_on_a: assert property (
    reclose_enable_setting_function_out == (switch_off_state_out == 3'h0)) else $error("active flag wrong");
  busy_hold_a: assert property (fault_busy_out && !nv_load_in &&
    !sw_req_in[2].on_req && !sw_req_in[2].off_req |=> $stable(switch_off_state_out))
    else $error("switch state changed during fault");
  own_source_a: assert property ($fell(switch_off_state_out[1]) |->
    $past(sw_req_in[1].on_req || nv_load_in)) else $error("switched on by other source");
  shot_limit_a: assert property (reclose_cmd_out |-> shots_reg < 4'h8)
    else $error("too many reclose commands");
  start_cause_a: assert property ($rose(started_out) |->
    $past(|(src_trip_in & src_reclose_en_in))) else $error("start without enabled trip");
  breaker_check_a: assert property ($rose(started_out) |->
    $past(cb_ready_in || !cb_check_en_in)) else $error("start with breaker not ready");
  first_ready_a: assert property (cycle_ready_out[0] |->
    reclose_enable_setting_function_out && !started_out && !lockout_out) else $error("ready wrong");
  cycle_order_a: assert property (started_out && $past(started_out) |->
    cycle_out >= $past(cycle_out)) else $error("cycle index went back");
  idle_clear_a: assert property (!fault_busy_out [*2] |->
    not_performable_out == 4'h0) else $error("not performable kept in idle");
endmodule : ars_sequencer_props

/* File: verif/ars_line_model.sv */
`timescale 1ns/1ps
module ars_line_model #(
  parameter int NUM_SRC = 4
) (
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  input  wire logic               fault_in,
  input  wire logic [7:0]         delay_in,
  input  wire logic [NUM_SRC-1:0] src_in,
  input  wire logic               cb_ok_in,
  output logic [NUM_SRC-1:0]      pickup_out,
  output logic [NUM_SRC-1:0]      trip_out,
  output logic                    cb_ready_out
);
  logic [7:0] age_reg;
  logic       on_reg;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      on_reg  <= 1'h0;
      age_reg <= 8'h00;
    end else if (fault_in) begin
      on_reg  <= 1'h1;
      age_reg <= 8'h00;
    end else if (on_reg) begin
      age_reg <= age_reg + 8'h01;
      // Breaker clears the fault a few cycles after trip
      if (age_reg == delay_in + 8'h03) on_reg <= 1'h0;
    end
  end
  assign pickup_out   = on_reg ? src_in : '0;
  assign trip_out     = (on_reg && age_reg >= delay_in) ? src_in : '0;
  assign cb_ready_out = cb_ok_in;
endmodule : ars_line_model

/* File: verif/ars_sequencer_test.sv */
`timescale 1ns/1ps
module ars_sequencer_test;
  import ars_pkg::*;
  logic               clk = 1'h0;
  logic               rst = 1'h1;
  ars_switch_req_type sw [ARS_NUM_SWITCH];
  ars_cycle_set_type  sets [ARS_NUM_SETS];
  ars_mode_type       mode = ARS_MODE_NO_ACTION;
  logic [3:0]         src = 4'h1;
  logic [3:0]         pick, trip, np;
  logic [7:0]         dly = 8'h02;
  logic [7:0]         rdy;
  logic [2:0]         off_st, cyc;
  logic               nonsc = 1'h0, cb_chk = 1'h0, cb_ok = 1'h1, fault = 1'h0;
  logic               cb_rdy, act, started, tp, cmd, lock, busy;
  logic [3:0]         en = 4'h1;
  logic               nvl = 1'h0;
  logic [2:0]         nvs = 3'h0;
  int                 failures = 0, checks_done = 0;
  always #25 clk = ~clk;
  ars_sequencer #(.TICK_CYCLES(4)) dut (
    .core_clk_in(clk), .rst_in(rst), .sw_req_in(sw), .nv_load_in(nvl), .nv_state_in(nvs),
    .reclose_timing_mode_in(mode), .cycle_set_in(sets), .src_reclose_en_in(en),
    .src_pickup_in(pick), .src_trip_in(trip), .nonsc_trip_in(nonsc), .cb_ready_in(cb_rdy),
    .cb_check_en_in(cb_chk), .switch_off_state_out(off_st), .reclose_enable_setting_function_out(act),
    .cycle_ready_out(rdy), .started_out(started), .cycle_out(cyc), .three_pole_out(tp),
    .reclose_cmd_out(cmd), .lockout_out(lock), .not_performable_out(np), .fault_busy_out(busy));
  ars_line_model line (.clk_in(clk), .rst_in(rst), .fault_in(fault), .delay_in(dly),
    .src_in(src), .cb_ok_in(cb_ok), .pickup_out(pick), .trip_out(trip), .cb_ready_out(cb_rdy));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic req(input int s, input logic on, input logic off);
    @(posedge clk) sw[s] <= '{on, off};
    @(posedge clk) sw[s] <= '0;
    @(posedge clk) #1;
  endtask : req
  task automatic run_fault(input logic [3:0] s, input logic [7:0] d);
    @(posedge clk) src <= s;
    dly <= d;
    fault <= 1'h1;
    @(posedge clk) fault <= 1'h0;
    for (int i = 0; i < 200 && trip == 4'h0; i++) begin
      @(posedge clk);
      #1;
    end
    repeat (2) @(posedge clk);
    #1;
  endtask : run_fault
  task automatic idle_wait();
    for (int i = 0; i < 14000 && busy !== 1'h0; i++) begin
      @(posedge clk);
      #1;
    end
    chk(8'(busy), 8'h00);
  endtask : idle_wait
  task automatic reset_pulse();
    @(posedge clk) rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    #1;
    chk(8'(started), 8'h00);
    chk(8'(rdy[0]), 8'h01);
    chk(8'(busy), 8'h00);
  endtask : reset_pulse
  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    results();
  end
  initial begin
    foreach (sw[i]) sw[i] = '0;
    foreach (sets[i]) sets[i] = '{16'h0010, 16'h0003, 1'h1, 1'h1};
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    #1;
    chk(8'(off_st), 8'h00);
    chk(8'(rdy[0]), 8'h01);
    req(1, 1'h0, 1'h1);
    chk(8'(off_st), 8'h02);
    chk(8'(act), 8'h00);
    req(0, 1'h1, 1'h0);
    chk(8'(off_st), 8'h02);
    req(1, 1'h1, 1'h0);
    chk(8'(act), 8'h01);
    @(posedge clk) nvl <= 1'h1;
    nvs <= 3'h5;
    @(posedge clk) nvl <= 1'h0;
    @(posedge clk) #1;
    chk(8'(off_st), 8'h05);
    chk(8'(rdy[0]), 8'h00);
    req(0, 1'h1, 1'h0);
    chk(8'(off_st), 8'h04);
    req(2, 1'h1, 1'h0);
    chk(8'(act), 8'h01);
    @(posedge clk) nonsc <= 1'h1;
    req(1, 1'h0, 1'h1);
    chk(8'(busy), 8'h01);
    chk(8'(off_st), 8'h00);
    chk(8'(started), 8'h00);
    @(posedge clk) nonsc <= 1'h0;
    run_fault(4'h1, 8'h02);
    chk({7'h00, started}, 8'h01);
    chk(8'(cyc), 8'h00);
    for (int i = 0; i < 400 && cmd !== 1'h1; i++) begin
      @(posedge clk);
      #1;
    end
    chk(8'(cmd), 8'h01);
    chk(rdy, 8'h02);
    reset_pulse();
    run_fault(4'h2, 8'h02);
    chk(8'(started), 8'h00);
    idle_wait();
    @(posedge clk) en <= 4'h3;
    run_fault(4'h2, 8'h02);
    chk(8'(started), 8'h01);
    reset_pulse();
    @(posedge clk) en <= 4'h1;
    cb_chk <= 1'h1;
    cb_ok <= 1'h0;
    run_fault(4'h1, 8'h02);
    chk(8'(started), 8'h00);
    chk(8'(lock), 8'h01);
    @(posedge clk) cb_chk <= 1'h0;
    cb_ok <= 1'h1;
    idle_wait();
    @(posedge clk) mode <= ARS_MODE_ACTION;
    sets[0].action_ms <= 16'h0002;
    sets[1].three_pole <= 1'h0;
    run_fault(4'h1, 8'h28);
    chk(8'(cyc), 8'h01);
    chk(8'(np[0]), 8'h01);
    chk(8'(tp), 8'h00);
    idle_wait();
    @(posedge clk) for (int i = 1; i < ARS_NUM_SETS; i++) sets[i].start_allowed <= 1'h0;
    run_fault(4'h1, 8'h28);
    chk(8'(started), 8'h00);
    chk(8'(lock), 8'h01);
    idle_wait();
    results();
  end
endmodule : ars_sequencer_test
bind ars_sequencer ars_sequencer_props #(.NUM_SRC(NUM_SRC), .NUM_CYCLES(NUM_CYCLES)) u_props (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .sw_req_in(sw_req_in), .nv_load_in(nv_load_in),
  .src_reclose_en_in(src_reclose_en_in), .src_trip_in(src_trip_in), .cb_ready_in(cb_ready_in),
  .cb_check_en_in(cb_check_en_in), .switch_off_state_out(switch_off_state_out),
  .reclose_enable_setting_function_out(reclose_enable_setting_function_out), .cycle_ready_out(cycle_ready_out),
  .started_out(started_out), .cycle_out(cycle_out), .reclose_cmd_out(reclose_cmd_out),
  .lockout_out(lockout_out), .not_performable_out(not_performable_out),
  .fault_busy_out(fault_busy_out));
